// [rtl/lfwt_defs.vh]
`ifndef LFWT_DEFS_VH
`define LFWT_DEFS_VH

// ----------------------------------------------------------------------------
// Register indices and address width (byte address = 4 * index)
// ----------------------------------------------------------------------------
`define LFWT_IDX_PWR_CTRL      8'h87
`define LFWT_IDX_TMR_CTRL      8'hFB
`define LFWT_IDX_STATUS        8'h40
`define LFWT_ADDR_W            10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LFWT_TMR_RUN_BIT       7
`define LFWT_TMR_FLAG_BIT      6
`define LFWT_TMR_SEL_MSB       3
`define LFWT_TMR_SEL_LSB       0
`define LFWT_PWR_STOP_BIT      1
`define LFWT_PWR_IDLE_BIT      0
`define LFWT_STS_STOP_BIT      0
`define LFWT_STS_IDLE_BIT      1
`define LFWT_STS_OSC_BIT       2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LFWT_TMR_CTRL_RST      8'h00
`define LFWT_PWR_RST           2'h0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define LFWT_CORE_HZ           250000000
`define LFWT_LF_HZ             32768
`define LFWT_LF_DIV            (`LFWT_CORE_HZ / `LFWT_LF_HZ)
`define LFWT_BASE_TICKS        21'h000200
`define LFWT_CNT_W             21
`define LFWT_PRE_W             16

`endif

// [rtl/lfwt_sync.v]
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Three-stage pin synchroniser, output moves when stages two and three agree
// ----------------------------------------------------------------------------
module lfwt_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             i_core_clk,
  input  wire             i_sys_rst,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg  [WIDTH-1:0] stage1_reg;
  reg  [WIDTH-1:0] stage2_reg;
  reg  [WIDTH-1:0] stage3_reg;
  reg  [WIDTH-1:0] out_reg;
  wire [WIDTH-1:0] agree;

  genvar g;

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stage1_reg <= RST_VAL;
      stage2_reg <= RST_VAL;
      stage3_reg <= RST_VAL;
    end else begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // One process owns all bits; a bit moves only when stages two and three agree
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_agree
      assign agree[g] = (stage2_reg[g] == stage3_reg[g]);
    end
  endgenerate

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_reg <= RST_VAL;
    end else begin
      out_reg <= (stage3_reg & agree) | (out_reg & ~agree);
    end
  end

  assign o_sync = out_reg;

endmodule // lfwt_sync

// [rtl/lfwt_top.v]
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`include "lfwt_defs.vh"

// Function
// - LF oscillator on when timer or watchdog enabled
// - Elapsed interval raises request, wakes deep sleep
// - Control bit 7 starts the timer
// - Bit 6 flag, cleared on interrupt accept
// - Codes 0-3 give 15.625 to 125 ms
// - Codes 4-7 give 0.25 to 2 s
// - Code 8 gives printed 4.0 period
// - Codes 9-11 give 8-32 s; rest reserved
// - Timer control at FB, fields reset zero
// - Power bit 1 enters deep sleep, stops HF
// - LF oscillator, watchdog follow own config in sleep
// - External irqs, timer, touch key end sleep
// - External reset also ends deep sleep
// - Power bit 0 enters idle, core halts
// - Any enabled interrupt ends idle
// - Power control at 87, write-only, reads zero
module lfwt_top #(
  parameter LF_DIV = `LFWT_LF_DIV
) (
  input  wire                      i_core_clk,
  input  wire                      i_sys_rst,
  input  wire [`LFWT_ADDR_W-1:0]   i_avs_address,
  input  wire                      i_avs_read,
  input  wire                      i_avs_write,
  input  wire [31:0]               i_avs_writedata,
  input  wire [3:0]                i_avs_byteenable,
  output wire [31:0]               o_avs_readdata,
  output wire                      o_avs_waitrequest,
  input  wire                      i_watchdog_timer_en,
  input  wire                      i_lf_irq_accept,
  input  wire                      i_irq_enabled_pending,
  input  wire [2:0]                i_ext_irq_inputs,
  input  wire                      i_touch_key_unit_irq,
  input  wire                      i_ext_rst_n,
  output wire                      o_lf_osc_en,
  output wire                      o_lf_tick,
  output wire                      o_lf_timer_irq,
  output wire                      o_hf_osc_en,
  output wire                      o_core_halt,
  output wire                      o_deep_sleep,
  output wire                      o_idle
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  reg                       run_reg;
  reg                       run_next;
  reg                       flag_reg;
  reg                       flag_next;
  reg  [3:0]                sel_reg;
  reg  [3:0]                sel_next;
  reg                       stop_reg;
  reg                       stop_next;
  reg                       idle_reg;
  reg                       idle_next;
  reg  [`LFWT_PRE_W-1:0]    pre_reg;
  reg  [`LFWT_PRE_W-1:0]    pre_next;
  reg                       tick_reg;
  reg                       tick_next;
  reg  [`LFWT_CNT_W-1:0]    cnt_reg;
  reg  [`LFWT_CNT_W-1:0]    cnt_next;
  reg                       ack_reg;
  reg  [31:0]               rdata_reg;
  reg  [31:0]               rdata_next;

  wire [2:0]                ext_irq_s;
  wire                      tk_irq_s;
  wire                      ext_rst_n_s;
  wire                      req;
  wire                      acc;
  wire                      wr_acc;
  wire                      rd_acc;
  wire [7:0]                idx;
  wire                      lane0;
  wire                      wr_tmr;
  wire                      wr_pwr;
  wire                      period_end;
  wire                      osc_on;
  wire                      stop_wake;
  wire                      ext_wake;
  wire                      tk_wake;
  wire                      tmr_wake;
  wire                      rst_wake;
  wire [`LFWT_CNT_W-1:0]    period;

  // --------------------------------------------------------------------------
  // Constants
  // --------------------------------------------------------------------------
  localparam [7:0]          TMR_RST  = `LFWT_TMR_CTRL_RST;
  localparam [1:0]          PWR_RST  = `LFWT_PWR_RST;
  // Ext reset pin idles high; its stages reset high so no false wake follows
  localparam [4:0]          SYNC_RST = 5'h10;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Terminal count in LF ticks; zero marks a reserved code
  function [`LFWT_CNT_W-1:0] period_ticks;
    input [3:0] sel;
    begin
      if (sel <= 4'hB) begin
        period_ticks = `LFWT_BASE_TICKS << sel;
      end else begin
        period_ticks = {`LFWT_CNT_W{1'b0}};
      end
    end
  endfunction

  // Word index of a byte address; the two low address bits are dropped, so misaligned bytes match too
  function [7:0] word_index;
    input [`LFWT_ADDR_W-1:0] addr;
    begin
      word_index = addr[`LFWT_ADDR_W-1:2];
    end
  endfunction

  // Write strobe of one register: completed write, low lane, index match
  function reg_hit;
    input       wr;
    input       lane;
    input [7:0] at;
    input [7:0] target;
    begin
      reg_hit = wr & lane & (at == target);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  lfwt_sync #(
    .WIDTH   (5),
    .RST_VAL (SYNC_RST)
  ) u_pin_sync (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_async    ({i_ext_rst_n, i_touch_key_unit_irq, i_ext_irq_inputs}),
    .o_sync     ({ext_rst_n_s, tk_irq_s, ext_irq_s})
  );

  // --------------------------------------------------------------------------
  // Bus slave: one wait cycle, then answer
  // --------------------------------------------------------------------------
  assign req               = i_avs_read | i_avs_write;
  assign acc               = req & ack_reg;
  assign wr_acc            = acc & i_avs_write;
  assign rd_acc            = acc & i_avs_read;
  assign idx               = word_index(i_avs_address);
  assign lane0             = i_avs_byteenable[0];
  assign wr_tmr            = reg_hit(wr_acc, lane0, idx, `LFWT_IDX_TMR_CTRL);
  assign wr_pwr            = reg_hit(wr_acc, lane0, idx, `LFWT_IDX_PWR_CTRL);
  assign o_avs_waitrequest = req & ~ack_reg;
  assign o_avs_readdata    = rdata_reg;

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Data is fetched in the wait cycle so it stands at the completing edge
  always @* begin
    rdata_next = 32'h0000_0000;
    if (req & ~ack_reg & i_avs_read) begin
      case (idx)
        `LFWT_IDX_TMR_CTRL: begin
          rdata_next[7:0] = {run_reg, flag_reg, 2'h0, sel_reg};
        end
        `LFWT_IDX_STATUS: begin
          rdata_next[`LFWT_STS_STOP_BIT] = stop_reg;
          rdata_next[`LFWT_STS_IDLE_BIT] = idle_reg;
          rdata_next[`LFWT_STS_OSC_BIT]  = osc_on;
        end
        // Mode bits are not readable, the word reads zero
        `LFWT_IDX_PWR_CTRL: begin
          rdata_next = 32'h0000_0000;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end else if (rd_acc) begin
      rdata_next = rdata_reg;
    end
  end

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // --------------------------------------------------------------------------
  // Timer control register
  // --------------------------------------------------------------------------
  always @* begin
    run_next  = run_reg;
    sel_next  = sel_reg;
    flag_next = flag_reg;
    if (wr_tmr) begin
      run_next  = i_avs_writedata[`LFWT_TMR_RUN_BIT];
      sel_next  = i_avs_writedata[`LFWT_TMR_SEL_MSB:`LFWT_TMR_SEL_LSB];
      flag_next = i_avs_writedata[`LFWT_TMR_FLAG_BIT];
    end else if (i_lf_irq_accept) begin
      flag_next = 1'b0;
    end
    // A period ending in the clearing cycle is never lost
    if (period_end) begin
      flag_next = 1'b1;
    end
  end

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      run_reg  <= TMR_RST[`LFWT_TMR_RUN_BIT];
      flag_reg <= TMR_RST[`LFWT_TMR_FLAG_BIT];
      sel_reg  <= TMR_RST[`LFWT_TMR_SEL_MSB:`LFWT_TMR_SEL_LSB];
    end else begin
      run_reg  <= run_next;
      flag_reg <= flag_next;
      sel_reg  <= sel_next;
    end
  end

  // --------------------------------------------------------------------------
  // Low-frequency clock source
  // --------------------------------------------------------------------------
  // Watchdog enable is honoured in every mode, sleep included
  assign osc_on = run_reg | i_watchdog_timer_en;

  // Prescaler clears while the oscillator is off, so a restart gives a full tick
  always @* begin
    pre_next  = pre_reg;
    tick_next = 1'b0;
    if (!osc_on) begin
      pre_next = {`LFWT_PRE_W{1'b0}};
    end else if (pre_reg >= LF_DIV - 1) begin
      pre_next  = {`LFWT_PRE_W{1'b0}};
      tick_next = 1'b1;
    end else begin
      pre_next = pre_reg + 1'b1;
    end
  end

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_reg  <= {`LFWT_PRE_W{1'b0}};
      tick_reg <= 1'b0;
    end else begin
      pre_reg  <= pre_next;
      tick_reg <= tick_next;
    end
  end

  // --------------------------------------------------------------------------
  // Interval counter
  // --------------------------------------------------------------------------
  // Reserved codes give zero and the counter then never fires
  assign period     = period_ticks(sel_reg);
  assign period_end = run_reg & tick_reg & (period != {`LFWT_CNT_W{1'b0}}) &
                      (cnt_reg >= period - 1'b1);

  always @* begin
    cnt_next = cnt_reg;
    if (!run_reg) begin
      cnt_next = {`LFWT_CNT_W{1'b0}};
    end else if (period_end) begin
      cnt_next = {`LFWT_CNT_W{1'b0}};
    end else if (tick_reg && period != {`LFWT_CNT_W{1'b0}}) begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_reg <= {`LFWT_CNT_W{1'b0}};
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // --------------------------------------------------------------------------
  // Power modes
  // --------------------------------------------------------------------------
  // Wake sources are levels so a request that is already up also ends sleep
  assign ext_wake  = |ext_irq_s;
  assign tk_wake   = tk_irq_s;
  assign tmr_wake  = flag_reg;
  assign rst_wake  = ~ext_rst_n_s;
  assign stop_wake = ext_wake | tk_wake | tmr_wake;

  always @* begin
    stop_next = stop_reg;
    idle_next = idle_reg;
    if (stop_reg && (stop_wake || rst_wake)) begin
      stop_next = 1'b0;
    end
    if (idle_reg && i_irq_enabled_pending) begin
      idle_next = 1'b0;
    end
    // A write in the wake cycle wins, so a fresh request is never lost
    if (wr_pwr) begin
      stop_next = i_avs_writedata[`LFWT_PWR_STOP_BIT];
      idle_next = i_avs_writedata[`LFWT_PWR_IDLE_BIT];
    end
  end

  always @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stop_reg <= PWR_RST[`LFWT_PWR_STOP_BIT];
      idle_reg <= PWR_RST[`LFWT_PWR_IDLE_BIT];
    end else begin
      stop_reg <= stop_next;
      idle_reg <= idle_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Core keeps its state while halted; software pads with NOPs after the write
  assign o_core_halt    = stop_reg | idle_reg;
  // Only a request: the oscillator gate itself sits in the clock unit
  assign o_hf_osc_en    = ~stop_reg;
  assign o_lf_osc_en    = osc_on;
  assign o_lf_tick      = tick_reg;
  assign o_lf_timer_irq = flag_reg;
  assign o_deep_sleep   = stop_reg;
  assign o_idle         = idle_reg;

endmodule // lfwt_top

// [sim/lfwt_top_asserts.sv]
`timescale 1ns/1ps

// ----------------------------------------
// Port checks of the wake timer block
// ----------------------------------------
module lfwt_checker (
  input wire        i_core_clk,
  input wire        i_sys_rst,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire        i_watchdog_timer_en,
  input wire        i_lf_irq_accept,
  input wire        i_irq_enabled_pending,
  input wire [2:0]  i_ext_irq_inputs,
  input wire        i_touch_key_unit_irq,
  input wire        i_ext_rst_n,
  input wire [31:0] o_avs_readdata,
  input wire        o_avs_waitrequest,
  input wire        o_lf_osc_en,
  input wire        o_lf_tick,
  input wire        o_lf_timer_irq,
  input wire        o_hf_osc_en,
  input wire        o_core_halt,
  input wire        o_deep_sleep,
  input wire        o_idle
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // A completing power-control write beats any wake source
  wire bus_wr = i_avs_write & ~o_avs_waitrequest;
  wire pin_wake = (|i_ext_irq_inputs) | i_touch_key_unit_irq | ~i_ext_rst_n;

  chk_osc_follow: assert property (i_watchdog_timer_en |-> o_lf_osc_en)
    else $error("LF oscillator off with watchdog on");
  chk_hf_stop: assert property (o_hf_osc_en == !o_deep_sleep)
    else $error("HF enable disagrees with deep sleep");
  chk_halt_mode: assert property (o_core_halt == (o_deep_sleep | o_idle))
    else $error("Core halt disagrees with modes");
  chk_one_wait: assert property ((i_avs_read | i_avs_write) & o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("Bus answer late");
  chk_read_upper: assert property (i_avs_read & !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h000000)
    else $error("Upper read bits not zero");
  chk_flag_wake: assert property (o_deep_sleep & o_lf_timer_irq & !bus_wr |=> !o_deep_sleep)
    else $error("Timer flag did not end deep sleep");
  chk_pin_wake: assert property ((pin_wake & !bus_wr) [*8] |=> !o_deep_sleep)
    else $error("Wake pin did not end deep sleep");
  chk_idle_wake: assert property (o_idle & i_irq_enabled_pending & !bus_wr |=> !o_idle)
    else $error("Pending interrupt did not end idle");
  chk_accept_clr: assert property (o_lf_timer_irq & i_lf_irq_accept & !o_lf_tick & !i_avs_write
    |=> !o_lf_timer_irq)
    else $error("Accept did not clear timer flag");
  chk_tick_pulse: assert property (o_lf_tick |=> !o_lf_tick [*3])
    else $error("LF ticks too close");

  cov_sleep_wake: cover property (o_deep_sleep ##1 !o_deep_sleep);
  cov_idle_wake: cover property (o_idle ##1 !o_idle);
  cov_flag_set: cover property (!o_lf_timer_irq ##1 o_lf_timer_irq);
endmodule // lfwt_checker

// [sim/lfwt_top_tb.sv]
`timescale 1ns/1ps

module lfwt_top_tb;
  localparam LF_DIV = 4;
  localparam PER0   = 512 * LF_DIV;
  localparam [9:0] A_TMR = 10'h3EC, A_PWR = 10'h21C, A_BAD = 10'h004, A_STS = 10'h100;
  reg         i_core_clk, i_sys_rst, i_avs_read, i_avs_write;
  reg  [9:0]  i_avs_address;
  reg  [31:0] i_avs_writedata;
  reg  [3:0]  i_avs_byteenable;
  reg         i_watchdog_timer_en, i_lf_irq_accept, i_irq_enabled_pending;
  reg  [2:0]  i_ext_irq_inputs;
  reg         i_touch_key_unit_irq, i_ext_rst_n;
  wire [31:0] o_avs_readdata;
  wire        o_avs_waitrequest, o_lf_osc_en, o_lf_tick, o_lf_timer_irq;
  wire        o_hf_osc_en, o_core_halt, o_deep_sleep, o_idle;
  integer     num_errors, samples_checked, cycles, t1, t2, k;
  reg  [31:0] rd;

  lfwt_top #(.LF_DIV(LF_DIV)) dut_u (.i_core_clk, .i_sys_rst, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
    .i_watchdog_timer_en, .i_lf_irq_accept, .i_irq_enabled_pending, .i_ext_irq_inputs,
    .i_touch_key_unit_irq, .i_ext_rst_n, .o_lf_osc_en, .o_lf_tick, .o_lf_timer_irq,
    .o_hf_osc_en, .o_core_halt, .o_deep_sleep, .o_idle);

  // ----------------------------------------
  // Clock, timeout, shared tasks
  // ----------------------------------------
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  // Whole run is about 16k cycles
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors = num_errors + 1;
      wrap_up;
    end
  end

  task wrap_up;
    begin
      if (num_errors == 0 && samples_checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  task check(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task tick(input integer n);
    repeat (n) @(posedge i_core_clk);
  endtask

  // Waitrequest and read data are taken at the rising edge that completes
  task bus(input wr, input [9:0] a, input [31:0] d);
    begin
      @(posedge i_core_clk);
      i_avs_address   <= a;
      i_avs_writedata <= d;
      i_avs_read      <= !wr;
      i_avs_write     <= wr;
      @(posedge i_core_clk);
      while (o_avs_waitrequest !== 1'b0) @(posedge i_core_clk);
      rd = o_avs_readdata;
      i_avs_read  <= 1'b0;
      i_avs_write <= 1'b0;
    end
  endtask

  // Software pads every mode write with twelve idle slots
  task mode_wr(input [31:0] d);
    begin
      bus(1, A_PWR, d); tick(12);
    end
  endtask

  task wait_flag(output integer t);
    begin
      @(negedge i_core_clk);
      while (o_lf_timer_irq !== 1'b1) @(negedge i_core_clk);
      t = cycles;
      @(posedge i_core_clk);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    begin
      bus(0, A_TMR, 0); check(rd, 32'h0);
      #1 check(o_hf_osc_en, 1'b1); check(o_lf_osc_en, 1'b0);
      bus(1, A_TMR, 32'hFF); bus(0, A_TMR, 0); check(rd, 32'hCF);
      i_avs_byteenable <= 4'h0;
      bus(1, A_TMR, 32'h00);
      i_avs_byteenable <= 4'hF;
      bus(0, A_TMR, 0); check(rd, 32'hCF);
      bus(1, A_BAD, 32'hFF); bus(0, A_BAD, 0); check(rd, 32'h0);
      bus(1, A_TMR, 32'h8C); tick(3000);
      #1 check(o_lf_timer_irq, 1'b0); check(o_lf_osc_en, 1'b1);
      bus(1, A_TMR, 32'h00); #1 check(o_lf_osc_en, 1'b0);
      tick(1); i_watchdog_timer_en <= 1'b1;
      tick(2); #1 check(o_lf_osc_en, 1'b1);
      t1 = 0;
      for (k = 0; k < 4 * LF_DIV; k = k + 1) begin
        tick(1); #1 t1 = t1 + o_lf_tick;
      end
      check(t1, 4);
      tick(1); i_watchdog_timer_en <= 1'b0;
    end
  endtask

  task t_period;
    begin
      bus(1, A_TMR, 32'h80); wait_flag(t1);
      i_lf_irq_accept <= 1'b1; tick(1); i_lf_irq_accept <= 1'b0;
      #1 check(o_lf_timer_irq, 1'b0);
      wait_flag(t2); check(t2 - t1, PER0);
      bus(1, A_TMR, 32'h00); bus(1, A_TMR, 32'h81); t1 = cycles; wait_flag(t2);
      check((t2 - t1 >= 2 * PER0 - 8) && (t2 - t1 <= 2 * PER0 + 8), 1'b1);
      bus(1, A_TMR, 32'h81); bus(0, A_TMR, 0); check(rd, 32'h81);
    end
  endtask

  task t_sleep;
    begin
      mode_wr(32'h02);
      #1 check(o_deep_sleep, 1'b1); check(o_hf_osc_en, 1'b0); check(o_core_halt, 1'b1);
      bus(0, A_STS, 0); check(rd, 32'h5);
      bus(0, A_PWR, 0); check(rd, 32'h0);
      wait_flag(t1); tick(2);
      #1 check(o_deep_sleep, 1'b0); check(o_hf_osc_en, 1'b1);
      bus(1, A_TMR, 32'h00);
      for (k = 0; k < 5; k = k + 1) begin
        mode_wr(32'h02);
        if (k < 3) i_ext_irq_inputs[k] <= 1'b1;
        i_touch_key_unit_irq <= (k == 3);
        i_ext_rst_n <= (k != 4);
        #1 check(o_deep_sleep, 1'b1);
        tick(10); #1 check(o_deep_sleep, 1'b0);
        tick(1); i_ext_irq_inputs <= 3'h0; i_touch_key_unit_irq <= 1'b0; i_ext_rst_n <= 1'b1;
        tick(8);
      end
    end
  endtask

  task t_idle;
    begin
      mode_wr(32'h01);
      #1 check(o_idle, 1'b1); check(o_core_halt, 1'b1); check(o_hf_osc_en, 1'b1);
      tick(4); #1 check(o_idle, 1'b1);
      tick(1); i_irq_enabled_pending <= 1'b1;
      tick(2); #1 check(o_idle, 1'b0); check(o_core_halt, 1'b0);
      tick(1); i_irq_enabled_pending <= 1'b0;
    end
  endtask

  initial begin
    num_errors = 0; samples_checked = 0; cycles = 0;
    i_sys_rst = 1'b1; i_avs_read = 1'b0; i_avs_write = 1'b0; i_avs_address = 10'h000;
    i_avs_writedata = 32'h0; i_avs_byteenable = 4'hF; i_watchdog_timer_en = 1'b0;
    i_lf_irq_accept = 1'b0; i_irq_enabled_pending = 1'b0; i_ext_irq_inputs = 3'h0;
    i_touch_key_unit_irq = 1'b0; i_ext_rst_n = 1'b1;
    tick(3); i_sys_rst <= 1'b0;
    t_regs; t_period; t_sleep; t_idle;
    wrap_up;
  end
endmodule // lfwt_top_tb

bind lfwt_top lfwt_checker chk_u (.i_core_clk, .i_sys_rst, .i_avs_read, .i_avs_write,
  .i_watchdog_timer_en, .i_lf_irq_accept, .i_irq_enabled_pending, .i_ext_irq_inputs,
  .i_touch_key_unit_irq, .i_ext_rst_n, .o_avs_readdata, .o_avs_waitrequest, .o_lf_osc_en,
  .o_lf_tick, .o_lf_timer_irq, .o_hf_osc_en, .o_core_halt, .o_deep_sleep, .o_idle);
